// [hw/aux_packet_pkg.sv]
// Overview of operation
// - Color depth codes 0100..0111 decode to 8, 10, 12 and 16 bits per component.
// - Code zero means depth not indicated; other codes are reserved for users.
// - Sideband bit 4 sets AV mute, bit 5 clears it, placed in the control packet.
// - All other control packet fields, packing and default phase, are computed here.
// - Incoming general control packets on the auxiliary input are always removed.
// - The video InfoFrame bundle is driven and sampled on the link symbol clock.
// - Bits 7:0 checksum default 67h; scan, bar valid, active info, color format zero.
// - Bits 19:16 aspect ratio default 8h; other fields up to bit 31 default zero.
// - Format code, repetition, content type, YCC range default zero; bits 15, 39 zero.
// - Four sixteen-bit bar position fields in bits 111:48 default to zero.
// - Bundle bit 112 set: no own video InfoFrame, incoming ones pass unchanged.
// - Bit 112 clear with nonzero field bits: insert InfoFrame built from those bits.
// - Bit 112 clear with all field bits zero: insert InfoFrame from default values.
// - While bit 112 is clear, incoming video InfoFrames are removed.
// - One general control packet per frame, started by the vertical sync rising edge.
// - At most one video InfoFrame per frame, started by the vertical sync rising edge.
package aux_packet_pkg;

   localparam int WORD_W      = 32;
   localparam int PKT_WORDS   = 8;
   localparam int IDX_W       = 3;
   localparam int BODY_W      = 224;
   localparam int HDR_W       = 24;
   localparam int GCP_W       = 6;
   localparam int AVI_FIELD_W = 112;
   localparam int AVI_CTRL    = 112;
   localparam int AVI_RSVD_A  = 15;
   localparam int AVI_RSVD_B  = 39;
   localparam int GCP_SET_BIT = 4;
   localparam int GCP_CLR_BIT = 5;
   localparam int SB0_CLR_BIT = 4;
   localparam int TYPE_LSB    = 0;

   // Packet header bytes.
   localparam logic [7:0] GCP_TYPE    = 8'h03;
   localparam logic [7:0] AVI_TYPE    = 8'h82;
   localparam logic [7:0] AVI_VERSION = 8'h02;
   localparam logic [7:0] AVI_LENGTH  = 8'h0D;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;

   // Color depth codes and their bits per component.
   localparam logic [3:0] DEPTH_NONE = 4'h0;
   localparam logic [3:0] DEPTH_8    = 4'h4;
   localparam logic [3:0] DEPTH_10   = 4'h5;
   localparam logic [3:0] DEPTH_12   = 4'h6;
   localparam logic [3:0] DEPTH_16   = 4'h7;
   localparam logic [4:0] BPC_NONE = 5'h00;
   localparam logic [4:0] BPC_8    = 5'h08;
   localparam logic [4:0] BPC_10   = 5'h0A;
   localparam logic [4:0] BPC_12   = 5'h0C;
   localparam logic [4:0] BPC_16   = 5'h10;
   localparam logic [3:0] PP_PHASE = 4'h0;

   // Default video InfoFrame fields: checksum 67h, aspect ratio 8h, rest zero.
   localparam logic [111:0] AVI_DEFAULT = 112'h0000_0000_0000_0000_0000_0008_0067;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_GEN  = 3'b010,
      ST_PASS = 3'b100
   } seq_state_type;

endpackage

// [hw/aux_packet_filter.sv]
`timescale 1ns/1ns
// Removes unwanted packets from the auxiliary input stream and registers the rest.
module aux_packet_filter
   import aux_packet_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   input  wire logic              avi_pass_i,
   input  wire logic              in_valid_i,
   input  wire logic              in_sop_i,
   input  wire logic              in_eop_i,
   input  wire logic [WORD_W-1:0] in_data_i,
   output logic                   in_ready_o,
   output logic                   out_valid_o,
   output logic                   out_sop_o,
   output logic                   out_eop_o,
   output logic [WORD_W-1:0]      out_data_o,
   input  wire logic              out_ready_i
);

   logic drop_q;
   logic take;
   logic is_gcp;
   logic is_avi;
   logic drop_now;
   logic valid_d;

   // A packet is judged by its header word; the verdict holds until its last word.
   assign take     = in_valid_i & in_ready_o;
   assign is_gcp   = in_data_i[TYPE_LSB +: 8] == GCP_TYPE;
   assign is_avi   = in_data_i[TYPE_LSB +: 8] == AVI_TYPE;
   assign drop_now = in_sop_i ? (is_gcp | (is_avi & ~avi_pass_i)) : drop_q;
   assign valid_d  = out_valid_o ? ~out_ready_i : (take & ~drop_now);

   // One-word stage; the ready flag is registered so it only opens when empty.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         drop_q      <= 1'b0;
         out_valid_o <= 1'b0;
         out_sop_o   <= 1'b0;
         out_eop_o   <= 1'b0;
         out_data_o  <= '0;
         in_ready_o  <= 1'b1;
      end else begin
         out_valid_o <= valid_d;
         in_ready_o  <= ~valid_d;
         if (take) begin
            drop_q     <= drop_now & ~in_eop_i;
            out_sop_o  <= in_sop_i;
            out_eop_o  <= in_eop_i;
            out_data_o <= in_data_i;
         end
      end
   end

   no_gcp_out_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      take && in_sop_i && is_gcp |=> !out_valid_o ##1 !(out_valid_o && out_data_o[7:0] == GCP_TYPE && out_sop_o))
      else $error("Control packet leaked through the filter.");

   avi_drop_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      take && in_sop_i && is_avi && !avi_pass_i && !in_eop_i |=> !out_valid_o && drop_q)
      else $error("Video InfoFrame not removed while insertion is on.");

   avi_pass_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      take && in_sop_i && is_avi && avi_pass_i |=> out_valid_o && out_sop_o && out_data_o == $past(in_data_i))
      else $error("Video InfoFrame not passed through while insertion is off.");

endmodule // aux_packet_filter

// [hw/aux_gcp_avi_field_source.sv]
`timescale 1ns/1ns
// Generates the control packet once per frame, and the video InfoFrame once per frame while bit 112 is clear,
// and merges them with the filtered auxiliary input stream. All inputs are on the link symbol clock.
module aux_gcp_avi_field_source
   import aux_packet_pkg::*;
(
   input  wire logic                  clock_i,
   input  wire logic                  rstn_i,
   input  wire logic                  vsync_i,
   input  wire logic [GCP_W-1:0]      gcp_i,
   input  wire logic [AVI_CTRL:0]     info_avi_i,
   input  wire logic                  aux_in_valid_i,
   input  wire logic                  aux_in_sop_i,
   input  wire logic                  aux_in_eop_i,
   input  wire logic [WORD_W-1:0]     aux_in_data_i,
   output logic                       aux_in_ready_o,
   output logic                       aux_out_valid_o,
   output logic                       aux_out_sop_o,
   output logic                       aux_out_eop_o,
   output logic [WORD_W-1:0]          aux_out_data_o,
   input  wire logic                  aux_out_ready_i,
   output logic [4:0]                 color_depth_bpc_o,
   output logic                       gen_busy_o
);

   // Maps a color depth code to bits per component; reserved codes give zero.
   function automatic logic [4:0] depth_bpc(input logic [3:0] code);
      unique case (code)
         DEPTH_8:  depth_bpc = BPC_8;
         DEPTH_10: depth_bpc = BPC_10;
         DEPTH_12: depth_bpc = BPC_12;
         DEPTH_16: depth_bpc = BPC_16;
         default: depth_bpc = BPC_NONE;
      endcase
   endfunction

   // Word 0 carries the three header bytes, words 1..7 the body bytes low first.
   function automatic logic [WORD_W-1:0] packet_word(input logic [HDR_W-1:0]  hdr,
                                                     input logic [BODY_W-1:0] body,
                                                     input logic [IDX_W-1:0]  idx);
      logic [IDX_W-1:0] slot;
      slot = idx - 3'h1;
      if (idx == '0) begin
         packet_word = {ZERO_BYTE, hdr};
      end else begin
         packet_word = body[slot*WORD_W +: WORD_W];
      end
   endfunction

   seq_state_type state_q;
   seq_state_type state_d;
   logic                   vsync_q;
   logic                   gcp_pend_q;
   logic                   avi_pend_q;
   logic                   gen_gcp_q;
   logic [IDX_W-1:0]       idx_q;
   logic [GCP_W-1:0]       gcp_hold_q;
   logic [AVI_FIELD_W-1:0] avi_hold_q;
   logic                   f_valid;
   logic                   f_sop;
   logic                   f_eop;
   logic [WORD_W-1:0]      f_data;
   logic                   f_ready;

   aux_packet_filter u_filter (
      .clock_i     (clock_i),
      .rstn_i      (rstn_i),
      .avi_pass_i  (info_avi_i[AVI_CTRL]),
      .in_valid_i  (aux_in_valid_i),
      .in_sop_i    (aux_in_sop_i),
      .in_eop_i    (aux_in_eop_i),
      .in_data_i   (aux_in_data_i),
      .in_ready_o  (aux_in_ready_o),
      .out_valid_o (f_valid),
      .out_sop_o   (f_sop),
      .out_eop_o   (f_eop),
      .out_data_o  (f_data),
      .out_ready_i (f_ready)
   );

   // Sync edge and the state of the generator.
   logic vs_rise;
   logic load;
   logic gen_on;
   logic last_word;
   logic sending_gcp;
   logic sending_avi;
   logic avi_nonzero;
   logic f_take;
   assign vs_rise     = vsync_i & ~vsync_q;
   assign load        = ~aux_out_valid_o | aux_out_ready_i;
   assign gen_on      = state_q == ST_GEN;
   assign last_word   = idx_q == IDX_W'(PKT_WORDS - 1);
   assign sending_gcp = gen_on & gen_gcp_q;
   assign sending_avi = gen_on & ~gen_gcp_q;
   assign avi_nonzero = |info_avi_i[AVI_FIELD_W-1:0];
   assign f_ready     = (state_q == ST_PASS) & load;
   assign f_take      = f_valid & f_ready;

   // Control packet body: mute flags, color depth with packing phase, default phase.
   logic [3:0]        color_depth_code;
   logic              def_phase;
   logic [7:0]        sb0;
   logic [7:0]        sb1;
   logic [7:0]        sb2;
   logic [BODY_W-1:0] gcp_body;
   assign color_depth_code = (depth_bpc(gcp_hold_q[3:0]) == BPC_NONE) ? DEPTH_NONE : gcp_hold_q[3:0];
   assign def_phase = (color_depth_code == DEPTH_NONE) | (color_depth_code == DEPTH_8);
   assign sb0       = {3'h0, gcp_hold_q[GCP_CLR_BIT], 3'h0, gcp_hold_q[GCP_SET_BIT]};
   assign sb1       = {PP_PHASE, color_depth_code};
   assign sb2       = {7'h00, def_phase};
   assign gcp_body  = {(BODY_W - 24)'(0), sb2, sb1, sb0};

   // Video InfoFrame body: captured fields with reserved bits forced low.
   logic [AVI_FIELD_W-1:0] avi_clean;
   logic [BODY_W-1:0]      avi_body;
   logic [WORD_W-1:0]      gen_word;
   always_comb begin
      avi_clean             = avi_hold_q;
      avi_clean[AVI_RSVD_A] = 1'b0;
      avi_clean[AVI_RSVD_B] = 1'b0;
   end
   assign avi_body = {(BODY_W - AVI_FIELD_W)'(0), avi_clean};
   assign gen_word = gen_gcp_q ? packet_word({ZERO_BYTE, ZERO_BYTE, GCP_TYPE}, gcp_body, idx_q)
                               : packet_word({AVI_LENGTH, AVI_VERSION, AVI_TYPE}, avi_body, idx_q);

   // Sequencer: generated packets take priority over passthrough at packet boundaries.
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (load && (gcp_pend_q || avi_pend_q)) begin
               state_d = ST_GEN;
            end else if (load && f_valid) begin
               state_d = ST_PASS;
            end
         end
         ST_GEN: begin
            if (load && last_word) begin
               state_d = ST_IDLE;
            end
         end
         ST_PASS: begin
            if (f_take && f_eop) begin
               state_d = ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // Packet selection, word counter and the registered output stage.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_q         <= ST_IDLE;
         gen_gcp_q       <= 1'b0;
         idx_q           <= '0;
         aux_out_valid_o <= 1'b0;
         aux_out_sop_o   <= 1'b0;
         aux_out_eop_o   <= 1'b0;
         aux_out_data_o  <= '0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE && load) begin
            gen_gcp_q <= gcp_pend_q;
            idx_q     <= '0;
         end
         if (load) begin
            aux_out_valid_o <= gen_on | f_take;
            aux_out_sop_o   <= gen_on ? (idx_q == '0) : f_sop;
            aux_out_eop_o   <= gen_on ? last_word : f_eop;
            aux_out_data_o  <= gen_on ? gen_word : f_data;
            if (gen_on) begin
               idx_q <= idx_q + 3'h1;
            end
         end
      end
   end

   // Per-frame capture; a copy being sent is never overwritten and a sync edge during its sending is dropped.
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         vsync_q           <= 1'b0;
         gcp_pend_q        <= 1'b0;
         avi_pend_q        <= 1'b0;
         gcp_hold_q        <= '0;
         avi_hold_q        <= AVI_DEFAULT;
         color_depth_bpc_o <= BPC_NONE;
         gen_busy_o        <= 1'b0;
      end else begin
         vsync_q           <= vsync_i;
         color_depth_bpc_o <= depth_bpc(gcp_hold_q[3:0]);
         gen_busy_o        <= state_d == ST_GEN;
         if (sending_gcp && load && last_word) begin
            gcp_pend_q <= 1'b0;
         end
         if (sending_avi && load && last_word) begin
            avi_pend_q <= 1'b0;
         end
         if (vs_rise && !sending_gcp) begin
            gcp_pend_q <= 1'b1;
            gcp_hold_q <= gcp_i;
         end
         if (vs_rise && !sending_avi) begin
            avi_pend_q <= ~info_avi_i[AVI_CTRL];
            avi_hold_q <= avi_nonzero ? info_avi_i[AVI_FIELD_W-1:0] : AVI_DEFAULT;
         end
      end
   end

   gcp_per_frame_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      vs_rise && !sending_gcp |=> gcp_pend_q ##[1:40] (sending_gcp && idx_q == '0))
      else $error("Control packet not started after sync edge.");

   avi_disabled_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      vs_rise && info_avi_i[AVI_CTRL] && !sending_avi |=> !avi_pend_q)
      else $error("Video InfoFrame scheduled while insertion is off.");

   avi_fields_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      vs_rise && avi_nonzero && !info_avi_i[AVI_CTRL] && !sending_avi
      |=> avi_pend_q && avi_hold_q == $past(info_avi_i[AVI_FIELD_W-1:0]))
      else $error("Video InfoFrame fields not captured.");

   avi_default_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      vs_rise && !avi_nonzero && !sending_avi |=> avi_hold_q == AVI_DEFAULT)
      else $error("Video InfoFrame defaults not applied.");

   hold_stable_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      sending_avi && !last_word |=> $stable(avi_hold_q))
      else $error("Video InfoFrame copy changed while sending.");

   mute_bits_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      sending_gcp && load && idx_q == 3'h1
      |=> aux_out_data_o[0] == gcp_hold_q[GCP_SET_BIT] && aux_out_data_o[SB0_CLR_BIT] == gcp_hold_q[GCP_CLR_BIT])
      else $error("Mute flags misplaced in control packet.");

   depth_decode_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      gcp_hold_q[3:0] == DEPTH_12 ##1 $stable(gcp_hold_q) |=> color_depth_bpc_o == BPC_12)
      else $error("Color depth code decoded wrongly.");

   reserved_zero_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      sending_avi && load && idx_q == 3'h1 |=> !aux_out_data_o[AVI_RSVD_A])
      else $error("Reserved InfoFrame bit not zero.");

   // The second reserved bit sits in the second body word, so it is checked when that word loads.
   reserved_high_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      sending_avi && load && idx_q == 3'h2 |=> !aux_out_data_o[AVI_RSVD_B - WORD_W])
      else $error("Reserved InfoFrame bit in the second body word not zero.");

   packet_len_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      gen_on && idx_q == '0 && load |=> aux_out_sop_o ##[7:100] (aux_out_eop_o && aux_out_valid_o))
      else $error("Generated packet length wrong.");

endmodule // aux_gcp_avi_field_source

// [tb/aux_user_model.sv]
`timescale 1ns/1ns
// Model of the user logic: it drives the sideband bundles and feeds packets into the auxiliary input.
module aux_user_model
   import aux_packet_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              ready_i,
   output logic [GCP_W-1:0]       gcp_o,
   output logic [AVI_CTRL:0]      info_avi_o,
   output logic                   valid_o,
   output logic                   sop_o,
   output logic                   eop_o,
   output logic [WORD_W-1:0]      data_o
);
   // Counts words that were never accepted within the wait bound.
   int n_stuck = 0;

   // Everything idles low at time zero.
   initial begin
      gcp_o = 6'h00;
      info_avi_o = '0;
      valid_o = 1'b0;
      sop_o = 1'b0;
      eop_o = 1'b0;
      data_o = 32'h0000_0000;
   end

   // Sideband changes only after a falling edge; only legal depth codes are ever passed in.
   task automatic set_side(input logic [GCP_W-1:0] g, input logic [AVI_CTRL:0] a);
      @(negedge clock_i);
      gcp_o = g;
      info_avi_o = a;
   endtask

   // Sends one packet, holding each word until ready is seen high at a rising edge or 101 rising edges have passed.
   task automatic send_pkt(input logic [7:0] kind, input int n);
      int i;
      int k;
      for (i = 0; i < n; i++) begin
         @(negedge clock_i);
         valid_o = 1'b1;
         sop_o = (i == 0);
         eop_o = (i == n - 1);
         data_o = (i == 0) ? {24'h12_3456, kind} : (32'hA5A5_0000 | 32'(i));
         k = 0;
         @(posedge clock_i);
         while (!ready_i && k < 100) begin
            @(posedge clock_i);
            k++;
         end
         if (!ready_i) begin
            n_stuck++;
         end
      end
      @(negedge clock_i);
      valid_o = 1'b0;
      sop_o = 1'b0;
      eop_o = 1'b0;
      data_o = ~data_o;   // A released bus must not keep showing the last word.
   endtask
endmodule // aux_user_model

// [tb/test_aux_gcp_avi_field_source.sv]
`timescale 1ns/1ns
// Bench: per-frame packet generation, sideband capture and filtering of the input stream.
module test_aux_gcp_avi_field_source
   import aux_packet_pkg::*;
;
   logic              clock_i;
   logic              rstn_i;
   logic              vsync;
   logic              out_ready;
   logic [GCP_W-1:0]  gcp;
   logic [AVI_CTRL:0] info_avi;
   logic              in_valid, in_sop, in_eop, in_ready;
   logic [WORD_W-1:0] in_data, out_data;
   logic              out_valid, out_sop, out_eop, busy;
   logic [4:0]        bpc;
   logic [WORD_W-1:0] w [8];
   int                n;
   int                n_mismatch = 0;
   int                checked = 0;

   // Free-running link symbol clock.
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   aux_gcp_avi_field_source DUT (.clock_i(clock_i), .rstn_i(rstn_i), .vsync_i(vsync), .gcp_i(gcp),
      .info_avi_i(info_avi), .aux_in_valid_i(in_valid), .aux_in_sop_i(in_sop), .aux_in_eop_i(in_eop),
      .aux_in_data_i(in_data), .aux_in_ready_o(in_ready), .aux_out_valid_o(out_valid),
      .aux_out_sop_o(out_sop), .aux_out_eop_o(out_eop), .aux_out_data_o(out_data),
      .aux_out_ready_i(out_ready), .color_depth_bpc_o(bpc), .gen_busy_o(busy));

   aux_user_model u (.clock_i(clock_i), .ready_i(in_ready), .gcp_o(gcp), .info_avi_o(info_avi),
      .valid_o(in_valid), .sop_o(in_sop), .eop_o(in_eop), .data_o(in_data));

   // Prints the counts and the verdict, then stops.
   task automatic conclude();
      n_mismatch += u.n_stuck;
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Collects one output packet up to its end word; stall makes the consumer take every other cycle.
   // Words are read at the falling edge, where they have settled; the transfer completes at the next rising edge.
   task automatic get_pkt(input bit stall);
      int  k;
      logic done;
      n = 0;
      done = 1'b0;
      k = 0;
      while (!done && k < 400) begin
         @(negedge clock_i);
         out_ready = stall ? k[0] : 1'b1;
         if (out_valid === 1'b1 && out_ready) begin
            if (n < 8) w[n] = out_data;
            n++;
            done = out_eop;
         end
         k++;
      end
      @(negedge clock_i);
      out_ready = 1'b0;
      if (!done) begin
         n_mismatch++;
         conclude();
      end
   endtask

   // Counts output words offered during a window in which none may appear.
   task automatic quiet(input int cycles);
      int seen;
      seen = 0;
      repeat (cycles) begin
         @(negedge clock_i);
         if (out_valid !== 1'b0) seen++;
      end
      chk(32'(seen), 32'h0000_0000);
   endtask

   // One frame: capture at the sync edge, disturb the inputs, then check the control packet and, with bit 112 clear, the InfoFrame.
   task automatic frame(input logic [GCP_W-1:0] g, input logic [AVI_CTRL:0] a);
      logic [3:0]   depth;
      logic         dp;
      logic [111:0] f;
      depth = g[3:0];
      dp = (depth == 4'h0 || depth == 4'h4);
      f = (a[111:0] == '0) ? 112'h0000_0000_0000_0000_0000_0008_0067 : a[111:0];
      f[15] = 1'b0;
      f[39] = 1'b0;
      u.set_side(g, a);
      @(negedge clock_i);
      vsync = 1'b1;
      repeat (3) @(negedge clock_i);
      vsync = 1'b0;
      u.set_side(g ^ 6'h30, {a[112], ~a[111:0]});
      chk(32'(busy), 32'h0000_0001);
      get_pkt(depth[0]);
      chk(32'(n), 32'h0000_0008);
      chk(w[0], 32'h0000_0003);
      chk(w[1], {8'h00, 7'h00, dp, 4'h0, depth, 3'h0, g[5], 3'h0, g[4]});
      chk(w[2], 32'h0000_0000);
      chk(32'(bpc), (depth == 4'h4) ? 32'h8 : (depth == 4'h5) ? 32'hA : (depth == 4'h6) ? 32'hC
                    : (depth == 4'h7) ? 32'h10 : 32'h0);
      if (!a[112]) begin
         get_pkt(1'b0);
         chk(32'(n), 32'h0000_0008);
         chk(w[0], 32'h000D_0282);
         chk(w[1], f[31:0]);
         chk(w[2], f[63:32]);
         chk(w[3], f[95:64]);
         chk(w[4], {16'h0000, f[111:96]});
      end
      quiet(40);
      chk(32'(busy), 32'h0000_0000);
   endtask

   // Main sequence.
   initial begin
      rstn_i = 1'b0;
      vsync = 1'b0;
      out_ready = 1'b0;
      repeat (2) @(negedge clock_i);
      rstn_i = 1'b1;
      chk({in_ready, out_valid, busy, 5'h00}, 32'h0000_0080);
      chk(32'(bpc), 32'h0000_0000);
      for (int i = 0; i < 5; i++) begin
         frame({i[1:0], (i == 0) ? 4'h0 : 4'(3 + i)}, (i < 2) ? '0 : {1'b0, {14{8'h81}} ^ 112'(i)});
      end
      // Control and InfoFrame packets on the input are dropped; other kinds pass.
      u.set_side(6'h04, '0);
      fork
         begin
            u.send_pkt(8'h03, 3);
            u.send_pkt(8'h82, 3);
            u.send_pkt(8'h0A, 4);
         end
         get_pkt(1'b1);
      join
      chk(w[0], 32'h1234_560A);
      chk(w[3], 32'hA5A5_0003);
      chk(32'(n), 32'h0000_0004);
      // With own insertion disabled, an incoming InfoFrame passes and none is generated.
      u.set_side(6'h05, {1'b1, 112'h0});
      fork
         u.send_pkt(8'h82, 5);
         get_pkt(1'b0);
      join
      chk(w[0], 32'h1234_5682);
      chk(w[4], 32'hA5A5_0004);
      chk(32'(n), 32'h0000_0005);
      frame(6'h05, {1'b1, {14{8'h81}}});
      conclude();
   end

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      conclude();
   end
endmodule // test_aux_gcp_avi_field_source
